// ### hw/ipg_pkg.sv
/*
 * Constants and types for the transmit interpacket gap timer.
 * Assumes a 32-bit APB slave with a 12-bit byte address.
 */
package ipg_pkg;

   // ******************************
   // Register map: index, byte address is four times the index
   // ******************************
   localparam logic [9:0]  IDX_B2B_GAP  = 10'h02D;
   localparam logic [9:0]  IDX_CS_WIN   = 10'h02E;
   localparam logic [9:0]  IDX_NB2B_GAP = 10'h02F;
   localparam logic [9:0]  IDX_CTRL     = 10'h03C;
   localparam logic [9:0]  IDX_STATUS   = 10'h03D;
   localparam int          ADDR_W       = 12;

   // ******************************
   // Field layout and reset values
   // ******************************
   localparam int          GAP_W        = 7;
   localparam logic [6:0]  B2B_RST      = 7'h15;
   localparam logic [6:0]  CS_WIN_RST   = 7'h0C;
   localparam logic [6:0]  NB2B_RST     = 7'h12;
   localparam int          CTRL_FD_BIT  = 0;
   localparam int          CTRL_SPD_LSB = 1;
   localparam logic        CTRL_FD_RST  = 1'b0;
   localparam logic [1:0]  CTRL_SPD_RST = 2'h0;
   localparam int          ST_OK_BIT    = 0;
   localparam int          ST_DEF_BIT   = 1;
   localparam int          ST_PEND_BIT  = 2;

   // ******************************
   // Gap timing in transmit clocks
   // ******************************
   localparam int          CNT_W        = 8;
   localparam logic [7:0]  FD_B2B_EXTRA = 8'h03;
   localparam logic [7:0]  HD_B2B_EXTRA = 8'h06;
   localparam logic [7:0]  NB2B_EXTRA   = 8'h06;

   // Gap timer states
   typedef enum logic [1:0] {
      ST_READY = 2'b00,
      ST_GAP   = 2'b01,
      ST_DEFER = 2'b10
   } ipg_state_t;

   // Byte address of a register index
   function automatic logic [ADDR_W-1:0] ipg_addr(input logic [9:0] idx);
      ipg_addr = {idx, 2'b00};
   endfunction

endpackage

// ### hw/ipg_cfg_if.sv
/*
 * Bundle of gap settings passed between the register file and the link.
 * Assumes the owner drives every field from flip-flops.
 */
`timescale 1ns/1ps
interface ipg_cfg_if;
   logic [6:0] b2b_gap_field;
   logic [6:0] nb2b_gap_field;
   logic [6:0] cs_window_field;
   logic       full_duplex;

   modport src (output b2b_gap_field, nb2b_gap_field, cs_window_field, full_duplex);
   modport dst (input  b2b_gap_field, nb2b_gap_field, cs_window_field, full_duplex);
endinterface

// ### hw/ipg_sync2.sv
/*
 * Two flip-flop level synchroniser into the destination clock.
 * Assumes each bit is an independent level.
 */
`timescale 1ns/1ps
module ipg_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // First stage is read only by the second
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// ### hw/ipg_cfg_xfer.sv
/*
 * Toggle handshake that moves the gap settings into the link clock.
 * Assumes load is a one-cycle pclk pulse; settings are held while pending.
 */
`timescale 1ns/1ps
module ipg_cfg_xfer (
   input  wire logic pclk,
   input  wire logic tx_clk,
   input  wire logic presetn,
   ipg_cfg_if.dst    live,
   input  wire logic load,
   output logic      pending,
   ipg_cfg_if.src    link
);
   import ipg_pkg::*;

   logic [6:0] pub_b2b_q, pub_nb2b_q, pub_csw_q;
   logic       pub_fd_q, req_q, dirty_q, ack_s, req_s, req_seen_q;

   // Publish a snapshot once the previous one is acknowledged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pub_b2b_q  <= B2B_RST;
         pub_nb2b_q <= NB2B_RST;
         pub_csw_q  <= CS_WIN_RST;
         pub_fd_q   <= CTRL_FD_RST;
         req_q      <= 1'b0;
         dirty_q    <= 1'b0;
      end else if (dirty_q && (req_q == ack_s)) begin
         pub_b2b_q  <= live.b2b_gap_field;
         pub_nb2b_q <= live.nb2b_gap_field;
         pub_csw_q  <= live.cs_window_field;
         pub_fd_q   <= live.full_duplex;
         req_q      <= ~req_q;
         dirty_q    <= load;
      end else if (load) begin
         dirty_q    <= 1'b1;
      end
   end

   assign pending = dirty_q | (req_q != ack_s);

   ipg_sync2 #(.W(1)) u_req (.clk(tx_clk), .rst_n(presetn), .d(req_q), .q(req_s));
   ipg_sync2 #(.W(1)) u_ack (.clk(pclk), .rst_n(presetn), .d(req_seen_q), .q(ack_s));

   // Capture the stable snapshot on a request edge, then acknowledge
   always_ff @(posedge tx_clk or negedge presetn) begin
      if (!presetn) begin
         link.b2b_gap_field   <= B2B_RST;
         link.nb2b_gap_field  <= NB2B_RST;
         link.cs_window_field <= CS_WIN_RST;
         link.full_duplex     <= CTRL_FD_RST;
         req_seen_q           <= 1'b0;
      end else if (req_s != req_seen_q) begin
         link.b2b_gap_field   <= pub_b2b_q;
         link.nb2b_gap_field  <= pub_nb2b_q;
         link.cs_window_field <= pub_csw_q;
         link.full_duplex     <= pub_fd_q;
         req_seen_q           <= req_s;
      end
   end
endmodule

// ### hw/ipg_timer.sv
/*
 * Transmit interpacket gap timer with APB registers.
 * Assumes tx_frame_end and tx_frame_queued come from MAC logic on tx_clk,
 * crs comes straight from the PHY pin, and presetn resets both domains.
 */
// Local design decision: the APB slave port.
`timescale 1ns/1ps

// Notes on behaviour
// - Gap runs from last FCS nibble to preamble
// - Full duplex back-to-back: setting plus three
// - Half duplex back-to-back: setting plus six
// - Non-back-to-back: setting plus six clocks
// - Carrier sense passes two-stage synchroniser
// - Carrier inside window, half duplex non-back-to-back gap: defer, do not send
// - Carrier after window: keep timing, then send
// - Back-to-back field bits 6:0, reset 15h
// - Back-to-back field counts full 00h-7Fh range
// - Window field bits 6:0, reset 0Ch
// - Gap counted in transmit clock periods
// - Non-back-to-back field resets to 12h
module ipg_timer (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       psel,
   input  wire logic                       penable,
   input  wire logic                       pwrite,
   input  wire logic [ipg_pkg::ADDR_W-1:0] paddr,
   input  wire logic [31:0]                pwdata,
   output logic      [31:0]                prdata,
   output logic                            pready,
   output logic                            pslverr,
   input  wire logic                       tx_clk,
   input  wire logic                       tx_frame_end,
   input  wire logic                       tx_frame_queued,
   input  wire logic                       crs,
   output logic                            tx_gap_ok,
   output logic                            tx_defer
);
   import ipg_pkg::*;

   // ******************************
   // Register file (pclk domain)
   // ******************************
   logic [6:0]  b2b_q;
   logic [6:0]  nb2b_q;
   logic [6:0]  csw_q;
   logic        csw_b7_q;
   logic        fd_q;
   logic [1:0]  spd_q;
   logic        access;
   logic        wr_en;
   logic        hit;
   logic        cfg_load_q;
   logic        pending;
   logic [31:0] rdata_d;
   logic [1:0]  stat_s;
   logic [4:0]  sel;

   // One-hot register select, shared by the read mux, writes and handover
   function automatic logic [4:0] reg_sel(input logic [ADDR_W-1:0] addr);
      reg_sel = 5'h00;
      if (addr == ipg_addr(IDX_B2B_GAP)) begin
         reg_sel = 5'h01;
      end else if (addr == ipg_addr(IDX_CS_WIN)) begin
         reg_sel = 5'h02;
      end else if (addr == ipg_addr(IDX_NB2B_GAP)) begin
         reg_sel = 5'h04;
      end else if (addr == ipg_addr(IDX_CTRL)) begin
         reg_sel = 5'h08;
      end else if (addr == ipg_addr(IDX_STATUS)) begin
         reg_sel = 5'h10;
      end
   endfunction

   assign access = psel & penable;
   assign wr_en  = access & pwrite & pready;
   assign sel    = reg_sel(paddr);
   assign hit    = |sel;

   ipg_cfg_if cfg_live ();
   ipg_cfg_if cfg_link ();

   assign cfg_live.b2b_gap_field   = b2b_q;
   assign cfg_live.nb2b_gap_field  = nb2b_q;
   assign cfg_live.cs_window_field = csw_q;
   assign cfg_live.full_duplex     = fd_q;

   // Read mux over the decoded select; unmapped addresses read zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (sel[0]) begin
         rdata_d[6:0] = b2b_q;                        // Bit 7 reads zero
      end else if (sel[1]) begin
         rdata_d[7:0] = {csw_b7_q, csw_q};
      end else if (sel[2]) begin
         rdata_d[6:0] = nb2b_q;
      end else if (sel[3]) begin
         rdata_d[CTRL_FD_BIT]                 = fd_q;
         rdata_d[CTRL_SPD_LSB+1:CTRL_SPD_LSB] = spd_q;
      end else if (sel[4]) begin
         rdata_d[ST_OK_BIT]   = stat_s[0];
         rdata_d[ST_DEF_BIT]  = stat_s[1];
         rdata_d[ST_PEND_BIT] = pending;
      end
   end

   // One wait state so every bus output comes from a flip-flop
   // Response is decided in the first access cycle, shown in the second
   // Read data is zero outside a read response, so stale data never shows
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= access & ~pready;
         pslverr <= access & ~pready & ~hit;
         prdata  <= (access & ~pready & ~pwrite) ? rdata_d : 32'h0000_0000;
      end
   end

   // Writable gap and control fields
   // Writes land at the edge where pready is high
   // Bit 7 of the back-to-back field has no storage and reads zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         b2b_q    <= B2B_RST;
         csw_q    <= CS_WIN_RST;
         csw_b7_q <= 1'b0;
         nb2b_q   <= NB2B_RST;
         fd_q     <= CTRL_FD_RST;
         spd_q    <= CTRL_SPD_RST;
      end else if (wr_en) begin
         if (sel[0]) begin
            b2b_q <= pwdata[6:0];
         end else if (sel[1]) begin
            csw_q    <= pwdata[6:0];
            csw_b7_q <= pwdata[7];
         end else if (sel[2]) begin
            nb2b_q <= pwdata[6:0];
         end else if (sel[3]) begin
            fd_q  <= pwdata[CTRL_FD_BIT];
            spd_q <= pwdata[CTRL_SPD_LSB+1:CTRL_SPD_LSB];
         end
      end
   end

   // Any settings write schedules a transfer to the link
   // Status is read only, so writing it starts no transfer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_load_q <= 1'b0;
      end else begin
         cfg_load_q <= wr_en & hit & ~sel[4];
      end
   end

   // ******************************
   // Settings handover to the link clock
   // ******************************
   // One snapshot crosses under a toggle handshake, so the
   // link side never sees a half-updated set of fields
   ipg_cfg_xfer u_xfer (
      .pclk    (pclk),
      .tx_clk  (tx_clk),
      .presetn (presetn),
      .live    (cfg_live.dst),
      .load    (cfg_load_q),
      .pending (pending),
      .link    (cfg_link.src)
   );

   // Status bits are independent levels, so a bit-wise synchroniser is enough
   // A status read may lag the link by two pclk cycles
   ipg_sync2 #(.W(2)) u_stat (
      .clk   (pclk),
      .rst_n (presetn),
      .d     ({tx_defer, tx_gap_ok}),
      .q     (stat_s)
   );

   // ******************************
   // Gap timer (tx_clk domain)
   // ******************************
   // Timer state and the snapshot of settings for the running gap
   logic             crs_s;
   ipg_state_t       state_q;
   ipg_state_t       state_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] target_q;
   logic [CNT_W-1:0] target_d;
   logic [CNT_W-1:0] win_q;
   logic [CNT_W-1:0] win_d;
   logic             chk_q;
   logic             chk_d;

   // Carrier sense is asynchronous; nothing reads it before the second flop
   ipg_sync2 #(.W(1)) u_crs (.clk(tx_clk), .rst_n(presetn), .d(crs), .q(crs_s));

   // Gap length of the kind chosen at the end of a frame
   function automatic logic [CNT_W-1:0] gap_len(input logic [6:0] field,
                                                input logic [7:0] extra);
      gap_len = {1'b0, field} + extra;
   endfunction

   // Next state, counter and snapshot of the settings
   // At the frame-end edge the counter loads 1, then it steps once
   // per tx_clk until it reaches the target; gap ok rises at the edge
   // that finds it there, so the gap is exactly the target in clocks
   // A new frame end restarts the gap from any state
   always_comb begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      target_d = target_q;
      win_d    = win_q;
      chk_d    = chk_q;
      if (tx_frame_end) begin
         state_d = ST_GAP;
         cnt_d   = 8'h01;
         if (tx_frame_queued) begin
            chk_d = 1'b0;
            win_d = 8'h00;
            if (cfg_link.full_duplex) begin
               target_d = gap_len(cfg_link.b2b_gap_field, FD_B2B_EXTRA);
            end else begin
               target_d = gap_len(cfg_link.b2b_gap_field, HD_B2B_EXTRA);
            end
         end else begin
            chk_d    = ~cfg_link.full_duplex;
            win_d    = {1'b0, cfg_link.cs_window_field};
            target_d = gap_len(cfg_link.nb2b_gap_field, NB2B_EXTRA);
         end
      end else begin
         case (state_q)
            ST_GAP: begin
               // Carrier inside the window defers; later carrier is ignored
               if (chk_q && crs_s && (cnt_q <= win_q)) begin
                  state_d = ST_DEFER;
               end else if (cnt_q >= target_q) begin
                  state_d = ST_READY;
               end else begin
                  cnt_d = cnt_q + 8'h01;
               end
            end
            ST_DEFER: begin
               // Medium free again: time a full idle gap with fresh settings
               if (!crs_s) begin
                  state_d  = ST_GAP;
                  cnt_d    = 8'h01;
                  chk_d    = 1'b1;
                  win_d    = {1'b0, cfg_link.cs_window_field};
                  target_d = gap_len(cfg_link.nb2b_gap_field, NB2B_EXTRA);
               end
            end
            default: begin
               // Idle in half duplex: a busy medium holds off the next start
               if (!cfg_link.full_duplex && crs_s) begin
                  state_d = ST_DEFER;
               end
            end
         endcase
      end
   end

   // Timer registers; settings are latched only at a gap start
   // A settings change mid-gap therefore waits for the next gap
   always_ff @(posedge tx_clk or negedge presetn) begin
      if (!presetn) begin
         state_q  <= ST_READY;
         cnt_q    <= 8'h00;
         target_q <= 8'h00;
         win_q    <= 8'h00;
         chk_q    <= 1'b0;
      end else begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         target_q <= target_d;
         win_q    <= win_d;
         chk_q    <= chk_d;
      end
   end

   // ******************************
   // Link outputs (tx_clk domain)
   // ******************************
   // Link outputs straight from flip-flops
   // Decoded from the next state, so they move together with the state
   always_ff @(posedge tx_clk or negedge presetn) begin
      if (!presetn) begin
         tx_gap_ok <= 1'b0;
         tx_defer  <= 1'b0;
      end else begin
         tx_gap_ok <= (state_d == ST_READY);
         tx_defer  <= (state_d == ST_DEFER);
      end
   end

endmodule

// ### verif/ipg_timer_properties.sv
/*
 * Concurrent checks on the ports of the interpacket gap timer.
 * Assumes presetn resets both the pclk and the tx_clk domain.
 */
`timescale 1ns/1ps
module ipg_timer_props (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        tx_clk,
   input wire logic        tx_frame_end,
   input wire logic        tx_frame_queued,
   input wire logic        crs,
   input wire logic        tx_gap_ok,
   input wire logic        tx_defer
);
   // ******************************
   // Register bus
   // ******************************
   AST_ONE_WAIT: assert property (@(posedge pclk) disable iff (!presetn)
      psel && $rose(penable) |-> !pready ##1 pready) else $error("pready not after one wait");
   AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
      pready |=> !pready) else $error("pready longer than one cycle");
   AST_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
      pready |-> pslverr == !(paddr inside {12'hB4, 12'hB8, 12'hBC, 12'hF0, 12'hF4}))
      else $error("pslverr does not match address map");
   AST_B2B_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
      pready && !pwrite && paddr == 12'hB4 |-> prdata[31:7] == 25'h0)
      else $error("reserved bits of gap register read nonzero");
   // ******************************
   // Link side
   // ******************************
   AST_GAP_QUEUED: assert property (@(posedge tx_clk) disable iff (!presetn)
      tx_frame_end && tx_frame_queued |=> !tx_gap_ok [*3]) else $error("queued gap too short");
   AST_GAP_IDLE: assert property (@(posedge tx_clk) disable iff (!presetn)
      tx_frame_end && !tx_frame_queued |=> !tx_gap_ok [*6]) else $error("idle gap too short");
   AST_OK_CAUSE: assert property (@(posedge tx_clk) disable iff (!presetn)
      $fell(tx_gap_ok) |-> $past(tx_frame_end) || tx_defer) else $error("gap ok dropped alone");
   AST_DEFER_BLOCK: assert property (@(posedge tx_clk) disable iff (!presetn)
      tx_defer |-> !tx_gap_ok) else $error("gap ok while deferring");
   AST_CRS_SYNC: assert property (@(posedge tx_clk) disable iff (!presetn)
      $rose(tx_defer) |-> $past(crs, 3)) else $error("defer faster than synchroniser");
   AST_DEFER_RESTART: assert property (@(posedge tx_clk) disable iff (!presetn)
      $fell(tx_defer) |-> !tx_gap_ok [*3]) else $error("gap not restarted after deferral");
   // Main scenarios reached
   CV_QUEUED: cover property (@(posedge tx_clk) tx_frame_end && tx_frame_queued);
   CV_DEFER: cover property (@(posedge tx_clk) $rose(tx_defer));
   CV_SLVERR: cover property (@(posedge pclk) pready && pslverr);
endmodule

bind ipg_timer ipg_timer_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .tx_clk(tx_clk), .tx_frame_end(tx_frame_end),
   .tx_frame_queued(tx_frame_queued), .crs(crs), .tx_gap_ok(tx_gap_ok), .tx_defer(tx_defer));

// ### verif/ipg_phy_model.sv
/*
 * Carrier sense side of the attached PHY.
 * Assumes the bench calls carrier while a gap is being timed or while the link is idle.
 */
`timescale 1ns/1ps
module ipg_phy_model (
   input wire logic tx_clk,
   output logic     crs
);
   // Medium idle until the bench asks for carrier
   initial crs = 1'b0;

   // Raise carrier after a delay for a number of link cycles
   task automatic carrier(input int after, input int len);
      repeat (after) @(posedge tx_clk);
      crs <= 1'b1;
      repeat (len) @(posedge tx_clk);
      crs <= 1'b0;
   endtask
endmodule

// ### verif/ipg_timer_tb.sv
/*
 * Self-checking bench for the interpacket gap timer.
 * Assumes the PHY model drives crs and the bench drives APB and frame ends.
 */
`timescale 1ns/1ps
module ipg_timer_tb;
   import ipg_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, saw_defer;
   logic        tx_clk, tx_frame_end, tx_frame_queued, crs, tx_gap_ok, tx_defer;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rdat;
   int          n_mismatch, tests_run;

   // ******************************
   // Clocks, design and partner
   // ******************************
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      tx_clk = 1'b0;
      #7;
      forever #62.5 tx_clk = ~tx_clk;
   end
   ipg_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_clk(tx_clk), .tx_frame_end(tx_frame_end),
      .tx_frame_queued(tx_frame_queued), .crs(crs), .tx_gap_ok(tx_gap_ok), .tx_defer(tx_defer));
   ipg_phy_model phy (.tx_clk(tx_clk), .crs(crs));

   // ******************************
   // Tasks
   // ******************************
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask
   task final_report;
      $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // One APB transfer, held until pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      int k;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
      r = prdata;
      e = pslverr;
      chk("pready", pready, 1);
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, rdat, rerr);
      chk("rdata", rdat, e);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rdat, rerr);
   endtask
   // Wait until settings have reached the link side
   task cfg_wait;
      int k;
      k = 0;
      do begin apb(1'b0, 12'hF4, 32'h0, rdat, rerr); k++; end while (rdat[2] !== 1'b0 && k < 40);
      chk("pending", rdat[2], 0);
      chk("status", rdat[1:0], 32'h1);
   endtask
   // Frame end, then count link cycles until gap ok
   task automatic gap(input logic q, input int cs_at, input int cs_len, output int n);
      @(posedge tx_clk);
      tx_frame_end <= 1'b1; tx_frame_queued <= q;
      @(posedge tx_clk);
      tx_frame_end <= 1'b0; tx_frame_queued <= 1'b0;
      if (cs_len > 0) fork phy.carrier(cs_at, cs_len); join_none
      n = 0; saw_defer = 1'b0;
      @(negedge tx_clk);
      while (tx_gap_ok !== 1'b1 && n < 600) begin
         @(negedge tx_clk); n++; saw_defer |= tx_defer;
      end
   endtask
   function int exp_gap(logic fd, logic q, int b, int nb);
      return q ? b + (fd ? 3 : 6) : nb + 6;
   endfunction

   // ******************************
   // Main sequence and watchdog
   // ******************************
   initial begin
      int i, b, nb, n;
      logic fd, q;
      logic [1:0] spd;
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0;
      pwdata = 32'h0; tx_frame_end = 1'b0; tx_frame_queued = 1'b0; n_mismatch = 0; tests_run = 0;
      void'($urandom(32'h99f0));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rd(12'hB4, 32'h15);
      rd(12'hB8, 32'h0C);
      rd(12'hBC, 32'h12);
      rd(12'hF0, 32'h0);
      apb(1'b1, 12'h100, 32'hFF, rdat, rerr);
      chk("slverr", rerr, 1);
      wr(12'hB4, 32'h7F);
      rd(12'hB4, 32'h7F);
      for (i = 0; i < 8; i++) begin
         b = (i == 0) ? 0 : (i == 1) ? 127 : $urandom_range(0, 127);
         nb = $urandom_range(0, 127); fd = $urandom_range(0, 1); spd = $urandom_range(0, 3);
         q = (i < 2) ? 1'b1 : 1'($urandom_range(0, 1));
         wr(12'hB4, b); wr(12'hBC, nb); wr(12'hB8, nb / 2);
         wr(12'hF0, {29'h0, spd, fd});
         rd(12'hF0, {29'h0, spd, fd});
         cfg_wait;
         gap(q, 0, 0, n);
         chk("gap", n, exp_gap(fd, q, b, nb));
      end
      // Half duplex idle gaps with carrier inside and after the window
      wr(12'hF0, 32'h0); wr(12'hBC, 32'd20); wr(12'hB8, 32'd10); cfg_wait;
      gap(1'b0, 1, 3, n);
      chk("defer", saw_defer, 1);
      chk("restart", n > 26, 1);
      gap(1'b0, 16, 4, n);
      chk("defer", saw_defer, 0);
      chk("gap", n, 26);
      // Carrier while idle in half duplex defers, then a full idle gap follows
      phy.carrier(1, 3);
      @(negedge tx_clk);
      chk("idle defer", tx_defer, 1);
      repeat (40) @(negedge tx_clk);
      chk("idle gap ok", tx_gap_ok, 1);
      // New setting written mid-gap applies only to the next gap
      wr(12'hF0, 32'h1); wr(12'hB4, 32'h40); cfg_wait;
      fork begin repeat (12) @(posedge pclk); wr(12'hB4, 32'h5); end join_none
      gap(1'b1, 0, 0, n);
      chk("gap", n, 67);
      cfg_wait;
      gap(1'b1, 0, 0, n);
      chk("gap", n, 8);
      final_report;
   end
   initial begin
      #3000000;
      n_mismatch++;
      final_report;
   end
endmodule
